//--- common/nvm_ready_regs.vh
// register offsets, field positions and reset values of the nvm register block
`ifndef NVM_READY_REGS_VH
`define NVM_READY_REGS_VH

// controller register offsets, used as the bus word index
`define IDX_INT_ENABLE 4'h3
`define IDX_INT_FLAGS 4'h4
`define IDX_DATA_LOW 4'h6
`define IDX_DATA_HIGH 4'h7
`define IDX_ADDR_LOW 4'h8
`define IDX_ADDR_MID 4'h9
`define IDX_ADDR_EXT 4'ha
// own registers for the block's system interrupt and status
`define IDX_BUSY_STATUS 4'hb
`define IDX_EVT_STATUS 4'hc
`define IDX_EVT_MASK 4'hd
// field positions
`define BIT_EEPROM_READY 0
`define BIT_IN_PROGRESS 0
`define EVT_READY_RISE 0
`define EVT_READ_DONE 1
`define EVT_ACCESS 2
`define EVT_WIDTH 3
// reset values
`define RST_BYTE 8'h00
`define RST_DATA 16'h0000
`define RST_ADDR 24'h000000
`define RST_EVT 3'h0
// eeprom uses only the low eight data bits
`define EEPROM_DATA_BITS 8

`endif

//--- src/nvm_wb_slave.v
// classic wishbone slave front end: decodes word index, one-cycle ack
`timescale 1ns/10ps
`default_nettype none
module nvm_wb_slave #(
   parameter IDX_W = 4
) (
   input wire core_clk,
   input wire srst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   output wire wb_ack_o,
   output wire wrStrobe,
   output wire rdStrobe,
   output wire [IDX_W-1:0] regIndex,
   output wire lowLaneSel
);
   reg ackFf;
   wire request;

   assign request = wb_cyc_i & wb_stb_i & ~ackFf;
   // access takes effect in the cycle ack is raised, once per request
   assign wrStrobe = request & wb_we_i;
   assign rdStrobe = request & ~wb_we_i;
   assign regIndex = wb_adr_i[IDX_W+1:2];
   assign lowLaneSel = wb_sel_i[0];
   assign wb_ack_o = ackFf;

   always @(posedge core_clk) begin
      if (srst) begin
         ackFf <= 1'b0;
      end else begin
         ackFf <= request;
      end
   end
endmodule
`default_nettype wire

//--- src/nvm_event_irq.v
// sticky event status with mask, read-to-clear, one level interrupt
`timescale 1ns/10ps
`default_nettype none
`include "nvm_ready_regs.vh"
module nvm_event_irq #(
   parameter N = `EVT_WIDTH
) (
   input wire core_clk,
   input wire srst,
   input wire [N-1:0] events,
   input wire statusRead,
   input wire maskWrite,
   input wire [N-1:0] maskData,
   output wire [N-1:0] status,
   output wire [N-1:0] mask,
   output wire irq
);
   reg [N-1:0] status_ff;
   reg [N-1:0] mask_ff;
   wire [N-1:0] nxt_status;

   // an event in the clearing cycle survives the read
   assign nxt_status = (statusRead ? {N{1'b0}} : status_ff) | events;
   assign status = status_ff;
   assign mask = mask_ff;
   assign irq = |(status_ff & mask_ff);

   always @(posedge core_clk) begin
      if (srst) begin
         status_ff <= {N{1'b0}};
         mask_ff <= {N{1'b0}};
      end else begin
         status_ff <= nxt_status;
         if (maskWrite) begin
            mask_ff <= maskData;
         end
      end
   end
endmodule
`default_nettype wire

//--- src/nvm_ready_irq_data_addr_regs.v
// nvm controller register slice: eeprom-ready interrupt, data and address
//
// Behaviour
// [RQ1] bit 0 of interrupt enable register enables the eeprom-ready interrupt
// [RQ2] eeprom-ready request is a level: flag and enable both set
// [RQ3] software enables the interrupt only after starting a write or erase
// [RQ4] the handler must clear the enable bit
// [RQ5] ready flag held set while no eeprom programming is in progress
// [RQ6] writing one clears the ready flag, writing zero leaves it
// [RQ7] 16-bit data register holds the last value read, resets to zero
// [RQ8] eeprom accesses use only the low data byte
// [RQ9] data low byte at base, high byte at base plus one
// [RQ10] 24-bit address in three read/write bytes, resets to zero
// [RQ11] address register tracks the last accessed memory location
// [RQ12] only low address bits the memory needs are decoded
// [RQ13] busy indication is one while eeprom programming runs
// [RQ14] programming starts on a store after a write or erase command
// [RQ15] request is flag AND enable, falls the cycle after either clears
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "nvm_ready_regs.vh"
module nvm_ready_irq_data_addr_regs #(
   parameter EEPROM_ADDR_BITS = 8,
   parameter FLASH_ADDR_BITS = 15
) (
   input wire core_clk,
   input wire srst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire eepromInProgress,
   input wire memReadValid,
   input wire [15:0] memReadData,
   input wire memReadIsEeprom,
   input wire memAccessValid,
   input wire [23:0] memAccessAddr,
   input wire memAccessIsEeprom,
   input wire storeRequest,
   input wire writeCmdArmed,
   output reg programStart,
   output wire [23:0] memDecodeAddr,
   output wire [7:0] eepromWriteData,
   output wire eepromReadyIrq,
   output wire irq
);
   wire wrStrobe;
   wire rdStrobe;
   wire [3:0] regIndex;
   wire lowLaneSel;
   wire byteWrite;
   wire [7:0] wrByte;
   reg interruptEnable_ff;
   reg eepromReady_ff;
   reg nxt_eepromReady;
   reg [15:0] readData_ff;
   reg [23:0] address_ff;
   reg busyPrev_ff;
   wire [`EVT_WIDTH-1:0] events;
   wire [`EVT_WIDTH-1:0] evtStatus;
   wire [`EVT_WIDTH-1:0] evtMask;

   // keep only the address bits the targeted memory needs, see [RQ12]
   function [23:0] trimAddr;
      input [23:0] a;
      input isEeprom;
      begin
         if (isEeprom) begin
            trimAddr = a & ((24'h000001 << EEPROM_ADDR_BITS) - 24'h000001);
         end else begin
            trimAddr = a & ((24'h000001 << FLASH_ADDR_BITS) - 24'h000001);
         end
      end
   endfunction

   nvm_wb_slave #(
      .IDX_W(4)
   ) busSlave (
      .core_clk(core_clk),
      .srst(srst),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_ack_o(wb_ack_o),
      .wrStrobe(wrStrobe),
      .rdStrobe(rdStrobe),
      .regIndex(regIndex),
      .lowLaneSel(lowLaneSel)
   );

   assign byteWrite = wrStrobe & lowLaneSel;
   assign wrByte = wb_dat_i[7:0];

   // ready flag: set while idle, one-write clears, idle keeps re-setting it
   always @* begin
      nxt_eepromReady = eepromReady_ff;
      if (byteWrite && regIndex == `IDX_INT_FLAGS &&
          wrByte[`BIT_EEPROM_READY]) begin
         nxt_eepromReady = 1'b0; // see [RQ6]
      end
      if (!eepromInProgress) begin
         nxt_eepromReady = 1'b1; // see [RQ5] see [RQ13]
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         interruptEnable_ff <= 1'b0;
         eepromReady_ff <= 1'b0;
         readData_ff <= `RST_DATA;
         address_ff <= `RST_ADDR;
         busyPrev_ff <= 1'b0;
         programStart <= 1'b0;
      end else begin
         eepromReady_ff <= nxt_eepromReady;
         busyPrev_ff <= eepromInProgress;
         programStart <= storeRequest & writeCmdArmed; // see [RQ14]
         if (byteWrite && regIndex == `IDX_INT_ENABLE) begin
            interruptEnable_ff <= wrByte[`BIT_EEPROM_READY]; // see [RQ1]
         end
         // memory read path loads data; eeprom fills low byte, zeroes high byte
         if (memReadValid) begin
            if (memReadIsEeprom) begin
               readData_ff <= {8'h00, memReadData[7:0]}; // see [RQ8]
            end else begin
               readData_ff <= memReadData; // see [RQ7]
            end
         end else if (byteWrite && regIndex == `IDX_DATA_LOW) begin
            readData_ff[7:0] <= wrByte; // see [RQ9]
         end else if (byteWrite && regIndex == `IDX_DATA_HIGH) begin
            readData_ff[15:8] <= wrByte; // see [RQ9]
         end
         if (memAccessValid) begin
            address_ff <= memAccessAddr; // see [RQ11]
         end else if (byteWrite && regIndex == `IDX_ADDR_LOW) begin
            address_ff[7:0] <= wrByte; // see [RQ10]
         end else if (byteWrite && regIndex == `IDX_ADDR_MID) begin
            address_ff[15:8] <= wrByte; // see [RQ10]
         end else if (byteWrite && regIndex == `IDX_ADDR_EXT) begin
            address_ff[23:16] <= wrByte; // see [RQ10]
         end
      end
   end

   // see [RQ2] see [RQ15]
   assign eepromReadyIrq = eepromReady_ff & interruptEnable_ff;
   assign memDecodeAddr = trimAddr(address_ff, memAccessIsEeprom);
   assign eepromWriteData = readData_ff[7:0]; // see [RQ8]

   assign events[`EVT_READY_RISE] = busyPrev_ff & ~eepromInProgress;
   assign events[`EVT_READ_DONE] = memReadValid;
   assign events[`EVT_ACCESS] = memAccessValid;

   nvm_event_irq #(
      .N(`EVT_WIDTH)
   ) evtIrq (
      .core_clk(core_clk),
      .srst(srst),
      .events(events),
      .statusRead(rdStrobe && regIndex == `IDX_EVT_STATUS),
      .maskWrite(byteWrite && regIndex == `IDX_EVT_MASK),
      .maskData(wrByte[`EVT_WIDTH-1:0]),
      .status(evtStatus),
      .mask(evtMask),
      .irq(irq)
   );

   // read data registered with ack; unmapped indexes read zero
   always @(posedge core_clk) begin
      if (srst) begin
         wb_dat_o <= 32'h00000000;
      end else if (rdStrobe) begin
         case (regIndex)
            `IDX_INT_ENABLE: wb_dat_o <= {31'h0, interruptEnable_ff};
            `IDX_INT_FLAGS: wb_dat_o <= {31'h0, eepromReady_ff};
            `IDX_DATA_LOW: wb_dat_o <= {24'h0, readData_ff[7:0]};
            `IDX_DATA_HIGH: wb_dat_o <= {24'h0, readData_ff[15:8]};
            `IDX_ADDR_LOW: wb_dat_o <= {24'h0, address_ff[7:0]};
            `IDX_ADDR_MID: wb_dat_o <= {24'h0, address_ff[15:8]};
            `IDX_ADDR_EXT: wb_dat_o <= {24'h0, address_ff[23:16]};
            `IDX_BUSY_STATUS: wb_dat_o <= {31'h0, eepromInProgress};
            `IDX_EVT_STATUS: wb_dat_o <= {29'h0, evtStatus};
            `IDX_EVT_MASK: wb_dat_o <= {29'h0, evtMask};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- tb/nvm_regs_props.sv
// assertion checker for the nvm register slice
`timescale 1ns/10ps
`default_nettype none
module nvm_regs_props #(
   parameter EEPROM_ADDR_BITS = 8,
   parameter FLASH_ADDR_BITS = 15
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic memReadValid,
   input wire logic [15:0] memReadData,
   input wire logic memAccessValid,
   input wire logic [23:0] memAccessAddr,
   input wire logic memAccessIsEeprom,
   input wire logic storeRequest,
   input wire logic writeCmdArmed,
   input wire logic programStart,
   input wire logic [23:0] memDecodeAddr,
   input wire logic [7:0] eepromWriteData,
   input wire logic eepromReadyIrq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ena_off;
      s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == 4'h3
         && !wb_dat_i[0]);
   endsequence
   sequence s_ee_load;
      memAccessValid && memAccessIsEeprom ##1 memAccessIsEeprom;
   endsequence
   sequence s_fl_load;
      memAccessValid && !memAccessIsEeprom ##1 !memAccessIsEeprom;
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) &&
      $past(wb_stb_i))
      else $error("ack without request");
   a_irq_off: assert property (s_ena_off |=> !eepromReadyIrq)
      else $error("ready request stays after enable cleared");
   a_prog_start: assert property (!$past(srst) |->
      programStart == ($past(storeRequest) && $past(writeCmdArmed)))
      else $error("program start wrong");
   a_data_low: assert property (memReadValid |=>
      eepromWriteData == 8'($past(memReadData)))
      else $error("data low byte not loaded");
   a_decode_ee: assert property (s_ee_load |-> memDecodeAddr ==
      ($past(memAccessAddr) & ((24'h1 << EEPROM_ADDR_BITS) - 24'h1)))
      else $error("eeprom decode width wrong");
   a_decode_fl: assert property (s_fl_load |-> memDecodeAddr ==
      ($past(memAccessAddr) & ((24'h1 << FLASH_ADDR_BITS) - 24'h1)))
      else $error("flash decode width wrong");
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the nvm register slice
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic req = 1'b0;
   logic we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [3:0] sel = 4'h1;
   logic [31:0] dat = 32'h0;
   logic eepromInProgress = 1'b0;
   logic memReadValid = 1'b0;
   logic [15:0] memReadData = 16'h0;
   logic memReadIsEeprom = 1'b0;
   logic memAccessValid = 1'b0;
   logic [23:0] memAccessAddr = 24'hfedcba;
   logic memAccessIsEeprom = 1'b0;
   logic storeRequest = 1'b0;
   logic writeCmdArmed = 1'b0;
   wire [31:0] datO;
   wire ack, programStart, eepromReadyIrq, irq;
   wire [23:0] memDecodeAddr;
   wire [7:0] eepromWriteData;
   int bad_count = 0;
   int n_checks = 0;
   always #4 core_clk = ~core_clk;
   nvm_ready_irq_data_addr_regs u_nvm_ready_irq_data_addr_regs (.core_clk,
      .srst, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
      .eepromInProgress, .memReadValid, .memReadData, .memReadIsEeprom,
      .memAccessValid, .memAccessAddr, .memAccessIsEeprom, .storeRequest,
      .writeCmdArmed, .programStart, .memDecodeAddr, .eepromWriteData,
      .eepromReadyIrq, .irq);
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task bus(input logic w, input logic [3:0] i, input logic [7:0] d);
      int k;
      @(posedge core_clk);
      req <= 1'b1;
      we <= w;
      adr <= {26'h0, i, 2'h0};
      dat <= {24'h0, d};
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (ack !== 1'b1 && k < 16);
      if (ack !== 1'b1) begin
         bad_count++;
         tally_and_finish;
      end
      req <= 1'b0;
   endtask
   task wr(input logic [3:0] i, input logic [7:0] d);
      bus(1'b1, i, d);
   endtask
   task rd(input logic [3:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00);
      chk($sformatf("reg %h", i), {24'h0, e}, datO);
   endtask
   // one-cycle load pulses from the memory side
   task pr(input logic e, input logic [15:0] d);
      memReadIsEeprom <= e;
      memReadData <= d;
      memReadValid <= 1'b1;
      @(posedge core_clk);
      memReadValid <= 1'b0;
      @(posedge core_clk);
   endtask
   task pa(input logic e);
      memAccessIsEeprom <= e;
      memAccessValid <= 1'b1;
      @(posedge core_clk);
      memAccessValid <= 1'b0;
      @(posedge core_clk);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      rd(4'h3, 8'h00);
      rd(4'h4, 8'h01);
      for (logic [3:0] i = 4'h6; i <= 4'ha; i++) rd(i, 8'h00);
      rd(4'h5, 8'h00);
      rd(4'hc, 8'h00);
      chk("eeIrq", 32'h0, eepromReadyIrq);
      // programming is issued before the ready interrupt is enabled
      eepromInProgress <= 1'b1;
      wr(4'h4, 8'h00);
      rd(4'h4, 8'h01);
      wr(4'h4, 8'h01);
      rd(4'h4, 8'h00);
      rd(4'hb, 8'h01);
      wr(4'h3, 8'h01);
      rd(4'h3, 8'h01);
      chk("eeIrq", 32'h0, eepromReadyIrq);
      eepromInProgress <= 1'b0;
      rd(4'h4, 8'h01);
      rd(4'hb, 8'h00);
      chk("eeIrq", 32'h1, eepromReadyIrq);
      sel <= 4'h0;
      wr(4'h3, 8'h00);
      sel <= 4'h1;
      chk("eeIrq", 32'h1, eepromReadyIrq);
      wr(4'h3, 8'h00);
      chk("eeIrq", 32'h0, eepromReadyIrq);
      rd(4'hc, 8'h01);
      pr(1'b0, 16'hbeef);
      chk("eeData", 32'hef, eepromWriteData);
      rd(4'h6, 8'hef);
      rd(4'h7, 8'hbe);
      pr(1'b1, 16'h1234);
      rd(4'h6, 8'h34);
      rd(4'h7, 8'h00);
      wr(4'h7, 8'h5a);
      rd(4'h7, 8'h5a);
      wr(4'h8, 8'h11);
      wr(4'h9, 8'h22);
      wr(4'ha, 8'h33);
      rd(4'h8, 8'h11);
      rd(4'h9, 8'h22);
      rd(4'ha, 8'h33);
      rd(4'hc, 8'h02);
      wr(4'hd, 8'h04);
      rd(4'hd, 8'h04);
      chk("irq", 32'h0, irq);
      pa(1'b0);
      chk("decode", 32'h5cba, memDecodeAddr);
      rd(4'h8, 8'hba);
      chk("irq", 32'h1, irq);
      rd(4'h9, 8'hdc);
      rd(4'ha, 8'hfe);
      pa(1'b1);
      chk("decode", 32'hba, memDecodeAddr);
      rd(4'hc, 8'h04);
      chk("irq", 32'h0, irq);
      storeRequest <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("start", 32'h0, programStart);
      writeCmdArmed <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("start", 32'h1, programStart);
      tally_and_finish;
   end
endmodule
bind nvm_ready_irq_data_addr_regs nvm_regs_props #(
   .EEPROM_ADDR_BITS(EEPROM_ADDR_BITS), .FLASH_ADDR_BITS(FLASH_ADDR_BITS))
   u_nvm_regs_props (.core_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .memReadValid, .memReadData,
   .memAccessValid, .memAccessAddr, .memAccessIsEeprom, .storeRequest,
   .writeCmdArmed, .programStart, .memDecodeAddr, .eepromWriteData,
   .eepromReadyIrq);
`default_nettype wire
